/* File: include/fault_monitor_consts.svh */
// constants for the led driver fault monitor: field positions, reset values, counts
`ifndef FAULT_MONITOR_CONSTS_SVH
`define FAULT_MONITOR_CONSTS_SVH

// ----------------------------------------
// status register field positions
// ----------------------------------------
// first status: comp overvoltage ch1/ch2
`define FS1_COMPOV_CH1 0
`define FS1_COMPOV_CH2 1
// second status: overtemp and bootstrap uv per channel
`define FS2_OT_CH1 0
`define FS2_OT_CH2 1
`define FS2_BSTUV_CH1 2
`define FS2_BSTUV_CH2 3
// third status: warning, serial error, analog uv, power cycle, timeout count
`define FS3_WARN 0
`define FS3_SERR 1
`define FS3_AUV 2
`define FS3_PWRCYC 3
`define FS3_WDTO_LO 4
`define FS3_WDTO_HI 5

// ----------------------------------------
// reset values
// ----------------------------------------
`define FS1_RESET 8'h00
`define FS2_RESET 8'h00
`define FS3_RESET 8'h08
`define WD_TAP_RESET 5'h18
`define WARN_LIMIT_RESET 10'h3FF
// lockout value of the channel actions: switching off, comp discharged
`define ACTION_RESET 6'h03

// ----------------------------------------
// widths and timing
// ----------------------------------------
`define WD_COUNTER_BITS 25
`define WD_TAP_MAX 5'h18
`define SYNC_STAGES 2

`endif

/* File: include/fault_monitor_pkg.sv */
// types shared by the led driver fault monitor files
package fault_monitor_pkg;

	// synchronised analog comparator levels
	typedef struct packed {
		logic [1:0] switch_overtemp;
		logic [1:0] bootstrap_uv;
		logic [1:0] input_uv;
		logic [1:0] comp_ov;
		logic analog_bias_uv;
	} comparator_levels_t;

	// per channel actions toward the power stage
	typedef struct packed {
		logic [1:0] switching_enable;
		logic [1:0] force_low_side;
		logic [1:0] comp_discharge;
	} channel_action_t;

	// one adc result tagged with its source
	typedef enum logic [1:0] {
		ADC_SRC_DIGITAL_BIAS,
		ADC_SRC_LIMP_HOME,
		ADC_SRC_TEMPERATURE,
		ADC_SRC_OTHER
	} adc_source_t;

	typedef enum logic [1:0] {
		OP_NORMAL,
		OP_STAND_ALONE,
		OP_LIMP_HOME
	} op_mode_t;

endpackage

/* File: design/comparator_sync.sv */
// two-stage synchroniser for a vector of analog comparator levels
`timescale 1ns/10ps
module comparator_sync #(
	parameter int WIDTH = 9
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// levels
	input wire logic [WIDTH-1:0] async_level,
	output logic [WIDTH-1:0] sync_level
);

	logic [WIDTH-1:0] stage_one;
	logic [WIDTH-1:0] next_stage_one;
	logic [WIDTH-1:0] next_sync_level;

	always_comb begin
		next_stage_one = async_level;
		next_sync_level = stage_one;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage_one <= '0;
			sync_level <= '0;
		end else begin
			stage_one <= next_stage_one;
			sync_level <= next_sync_level;
		end
	end

endmodule

/* File: design/comm_watchdog.sv */
// communication watchdog with selectable tap and 2-bit timeout count
`timescale 1ns/10ps
`include "fault_monitor_consts.svh"
module comm_watchdog (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic watchdog_enable,
	input wire logic [4:0] watchdog_tap_select,
	input wire logic spi_activity,
	// result
	output logic expired,
	output logic [1:0] watchdog_timeout_count
);

	logic [`WD_COUNTER_BITS-1:0] counter;
	logic [`WD_COUNTER_BITS-1:0] next_counter;
	logic next_expired;
	logic [1:0] next_watchdog_timeout_count;
	logic tap_hit;

	always_comb begin
		// taps past the top bit fall back to the top bit instead of reading off the end
		tap_hit = (watchdog_tap_select > `WD_TAP_MAX) ? counter[`WD_COUNTER_BITS-1] : counter[watchdog_tap_select];
		next_counter = counter + `WD_COUNTER_BITS'(1);
		next_expired = 1'b0;
		next_watchdog_timeout_count = watchdog_timeout_count;
		if (!watchdog_enable || spi_activity) begin
			next_counter = '0;
		end else if (tap_hit) begin
			// restart after each expiry; count saturates at three
			next_counter = '0;
			next_expired = 1'b1;
			if (watchdog_timeout_count != 2'h3) begin
				next_watchdog_timeout_count = watchdog_timeout_count + 2'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			counter <= '0;
			expired <= 1'b0;
			watchdog_timeout_count <= 2'h0;
		end else begin
			counter <= next_counter;
			expired <= next_expired;
			watchdog_timeout_count <= next_watchdog_timeout_count;
		end
	end

endmodule

/* File: design/led_driver_fault_monitor.sv */
// fault flags, channel actions and measurement capture of a dual led buck driver
`timescale 1ns/10ps
`include "fault_monitor_consts.svh"

// Operation
// - bias supply stored as 8-bit code
// - limp-home input 10-bit, stored, used as reference
// - temperature 10-bit, refreshed on low-byte read
// - warning flag when temperature exceeds limit[9:2]
// - switch overtemp shuts channel, sets flag
// - serial error sets serial error flag
// - watchdog expiry counts, enters fallback mode
// - digital bias lockout resets logic, sets power-cycle
// - analog bias uv disables switching, sets flag
// - input uv stops channel, no flag
// - bootstrap uv forces low side, sets flag
// - comp overvoltage flag, diagnostic only
// - status read clears vanished faults at end
// - power-cycle flag cleared by third status read
module led_driver_fault_monitor (
	// clock and reset (reset is the digital bias lockout)
	input wire logic clk,
	input wire logic rst_n,
	// analog comparator levels, asynchronous
	input wire logic [1:0] switch_overtemp,
	input wire logic [1:0] bootstrap_uv,
	input wire logic [1:0] input_uv,
	input wire logic [1:0] comp_ov,
	input wire logic analog_bias_uv,
	// adc results
	input wire logic adc_valid,
	input wire fault_monitor_pkg::adc_source_t adc_source,
	input wire logic [9:0] adc_data,
	// serial interface events
	input wire logic serial_error,
	input wire logic spi_activity,
	input wire logic read_done_first,
	input wire logic read_done_second,
	input wire logic read_done_third,
	input wire logic read_die_temp_low,
	// configuration
	input wire logic [1:0] channel_enable,
	input wire logic [9:0] thermal_warning_limit,
	input wire logic watchdog_enable,
	input wire logic [4:0] watchdog_tap_select,
	input wire logic limp_home_select,
	// measurement registers
	output logic [7:0] digital_bias_supply,
	output logic [7:0] limp_ref_low_byte,
	output logic [7:0] limp_ref_high_byte,
	output logic [7:0] die_temp_low_byte,
	output logic [7:0] die_temp_high_byte,
	output logic [9:0] current_reference,
	// status registers
	output logic [7:0] fault_status_first,
	output logic [7:0] fault_status_second,
	output logic [7:0] fault_status_third,
	// power stage actions and mode
	output fault_monitor_pkg::channel_action_t channel_action,
	output fault_monitor_pkg::op_mode_t op_mode
);

	// ----------------------------------------
	// synchronised comparators
	// ----------------------------------------
	fault_monitor_pkg::comparator_levels_t raw_levels;
	fault_monitor_pkg::comparator_levels_t levels;

	assign raw_levels = '{switch_overtemp: switch_overtemp, bootstrap_uv: bootstrap_uv,
		input_uv: input_uv, comp_ov: comp_ov, analog_bias_uv: analog_bias_uv};

	// flags and actions trail the pins by three edges: two sync flops, one register
	comparator_sync #(
		.WIDTH($bits(fault_monitor_pkg::comparator_levels_t))
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.async_level(raw_levels),
		.sync_level(levels)
	);

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	logic wd_expired;
	logic [1:0] wd_count;

	// expiry is a one-cycle pulse; the mode change follows it one edge later
	comm_watchdog u_watchdog (
		.clk(clk),
		.rst_n(rst_n),
		.watchdog_enable(watchdog_enable),
		.watchdog_tap_select(watchdog_tap_select),
		.spi_activity(spi_activity),
		.expired(wd_expired),
		.watchdog_timeout_count(wd_count)
	);

	// ----------------------------------------
	// sticky flags with clear-on-read
	// ----------------------------------------
	// a flag survives a read while its condition is still present, and a new
	// event in the clearing cycle also wins because set is applied last
	function automatic logic sticky(input logic cur, input logic cond, input logic rd);
		logic v;
		v = cur;
		if (rd && !cond) begin
			v = 1'b0;
		end
		if (cond) begin
			v = 1'b1;
		end
		return v;
	endfunction

	// ----------------------------------------
	// measurement capture and flag next values
	// ----------------------------------------
	logic [9:0] live_temp;
	logic [9:0] next_live_temp;
	logic [9:0] held_temp;
	logic [9:0] next_held_temp;
	logic [9:0] limp_ref;
	logic [9:0] next_limp_ref;
	logic [7:0] next_digital_bias_supply;
	logic [7:0] next_first;
	logic [7:0] next_second;
	logic [7:0] next_third;
	logic warn_cond;
	logic next_serial_err;
	logic serial_err;

	always_comb begin
		next_live_temp = live_temp;
		next_limp_ref = limp_ref;
		next_digital_bias_supply = digital_bias_supply;
		if (adc_valid) begin
			case (adc_source)
				fault_monitor_pkg::ADC_SRC_DIGITAL_BIAS: begin
					// 8 msbs of the conversion, 5.33/255 v per step
					next_digital_bias_supply = adc_data[9:2];
				end
				fault_monitor_pkg::ADC_SRC_LIMP_HOME: begin
					next_limp_ref = adc_data;
				end
				fault_monitor_pkg::ADC_SRC_TEMPERATURE: begin
					next_live_temp = adc_data;
				end
				default: begin
				end
			endcase
		end
		// held copy changes only on a low-byte read so high byte stays coherent
		next_held_temp = read_die_temp_low ? live_temp : held_temp;
		warn_cond = live_temp[9:2] > thermal_warning_limit[9:2];
		next_serial_err = serial_error;

		next_first = fault_status_first;
		next_first[`FS1_COMPOV_CH1] = sticky(fault_status_first[`FS1_COMPOV_CH1],
			levels.comp_ov[0], read_done_first);
		next_first[`FS1_COMPOV_CH2] = sticky(fault_status_first[`FS1_COMPOV_CH2],
			levels.comp_ov[1], read_done_first);

		next_second = fault_status_second;
		next_second[`FS2_OT_CH1] = sticky(fault_status_second[`FS2_OT_CH1],
			levels.switch_overtemp[0], read_done_second);
		next_second[`FS2_OT_CH2] = sticky(fault_status_second[`FS2_OT_CH2],
			levels.switch_overtemp[1], read_done_second);
		next_second[`FS2_BSTUV_CH1] = sticky(fault_status_second[`FS2_BSTUV_CH1],
			levels.bootstrap_uv[0], read_done_second);
		next_second[`FS2_BSTUV_CH2] = sticky(fault_status_second[`FS2_BSTUV_CH2],
			levels.bootstrap_uv[1], read_done_second);

		next_third = fault_status_third;
		next_third[`FS3_WARN] = sticky(fault_status_third[`FS3_WARN], warn_cond, read_done_third);
		next_third[`FS3_SERR] = sticky(fault_status_third[`FS3_SERR], serial_err, read_done_third);
		next_third[`FS3_AUV] = sticky(fault_status_third[`FS3_AUV],
			levels.analog_bias_uv, read_done_third);
		// power-cycle is set only by reset, so a read always clears it
		next_third[`FS3_PWRCYC] = read_done_third ? 1'b0 : fault_status_third[`FS3_PWRCYC];
		// the timeout count is a live copy of the watchdog; a read leaves it alone
		next_third[`FS3_WDTO_HI:`FS3_WDTO_LO] = wd_count;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			live_temp <= 10'h000;
			held_temp <= 10'h000;
			limp_ref <= 10'h000;
			digital_bias_supply <= 8'h00;
			serial_err <= 1'b0;
			// only the power-cycle flag comes out of lockout set
			fault_status_first <= `FS1_RESET;
			fault_status_second <= `FS2_RESET;
			fault_status_third <= `FS3_RESET;
		end else begin
			live_temp <= next_live_temp;
			held_temp <= next_held_temp;
			limp_ref <= next_limp_ref;
			digital_bias_supply <= next_digital_bias_supply;
			serial_err <= next_serial_err;
			fault_status_first <= next_first;
			fault_status_second <= next_second;
			fault_status_third <= next_third;
		end
	end

	// ----------------------------------------
	// byte views of the measurements
	// ----------------------------------------
	// the two top bits sit alone in the high byte; its upper bits read as zero
	function automatic logic [7:0] low_byte(input logic [9:0] v);
		return v[7:0];
	endfunction

	function automatic logic [7:0] high_byte(input logic [9:0] v);
		return {6'h00, v[9:8]};
	endfunction

	logic [7:0] next_limp_low;
	logic [7:0] next_limp_high;
	logic [7:0] next_temp_low;
	logic [7:0] next_temp_high;

	always_comb begin
		next_limp_low = low_byte(next_limp_ref);
		next_limp_high = high_byte(next_limp_ref);
		next_temp_low = low_byte(next_held_temp);
		next_temp_high = high_byte(next_held_temp);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			limp_ref_low_byte <= 8'h00;
			limp_ref_high_byte <= 8'h00;
			die_temp_low_byte <= 8'h00;
			die_temp_high_byte <= 8'h00;
		end else begin
			limp_ref_low_byte <= next_limp_low;
			limp_ref_high_byte <= next_limp_high;
			die_temp_low_byte <= next_temp_low;
			die_temp_high_byte <= next_temp_high;
		end
	end

	// ----------------------------------------
	// operating mode
	// ----------------------------------------
	fault_monitor_pkg::op_mode_t next_op_mode;
	logic [9:0] next_current_reference;

	always_comb begin
		next_op_mode = op_mode;
		case (op_mode)
			fault_monitor_pkg::OP_NORMAL: begin
				if (wd_expired) begin
					next_op_mode = limp_home_select ? fault_monitor_pkg::OP_LIMP_HOME
						: fault_monitor_pkg::OP_STAND_ALONE;
				end
			end
			// an expiry while already in a fallback mode leaves the mode as it is; only the timeout count still advances
			fault_monitor_pkg::OP_STAND_ALONE, fault_monitor_pkg::OP_LIMP_HOME: begin
				// serial traffic returns control to the host
				if (spi_activity) begin
					next_op_mode = fault_monitor_pkg::OP_NORMAL;
				end
			end
			default: begin
				next_op_mode = fault_monitor_pkg::OP_NORMAL;
			end
		endcase
		next_current_reference = (op_mode == fault_monitor_pkg::OP_LIMP_HOME) ? limp_ref : 10'h000;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			op_mode <= fault_monitor_pkg::OP_NORMAL;
			current_reference <= 10'h000;
		end else begin
			op_mode <= next_op_mode;
			current_reference <= next_current_reference;
		end
	end

	// ----------------------------------------
	// channel actions
	// ----------------------------------------
	fault_monitor_pkg::channel_action_t next_action;

	always_comb begin
		next_action = '0;
		for (int ch = 0; ch < 2; ch++) begin
			// comp overvoltage deliberately absent: it is diagnostic only
			next_action.switching_enable[ch] = channel_enable[ch] && !levels.switch_overtemp[ch]
				&& !levels.input_uv[ch] && !levels.analog_bias_uv;
			next_action.force_low_side[ch] = levels.bootstrap_uv[ch];
			next_action.comp_discharge[ch] = levels.analog_bias_uv || levels.switch_overtemp[ch];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// lockout: switching off, comp node discharged
			channel_action <= `ACTION_RESET;
		end else begin
			channel_action <= next_action;
		end
	end

endmodule

/* File: tb/fault_monitor_properties.sv */
// port assertions for the led driver fault monitor
`timescale 1ns/10ps
module fault_monitor_checker (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// causes
	input wire logic [1:0] switch_overtemp,
	input wire logic [1:0] bootstrap_uv,
	input wire logic [1:0] input_uv,
	input wire logic [1:0] comp_ov,
	input wire logic analog_bias_uv,
	input wire logic adc_valid,
	input wire fault_monitor_pkg::adc_source_t adc_source,
	input wire logic [9:0] adc_data,
	input wire logic serial_error,
	input wire logic read_done_third,
	// effects
	input wire logic [7:0] digital_bias_supply,
	input wire logic [7:0] fault_status_first,
	input wire logic [7:0] fault_status_second,
	input wire logic [7:0] fault_status_third,
	input wire fault_monitor_pkg::channel_action_t channel_action
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// three sampled highs: two sync stages and the flag register
	chk_compov_diag_only: assert property (comp_ov[0] [*3] |=> fault_status_first[0] && $stable(channel_action))
		else $error("comp overvoltage flag missing or action taken");
	chk_overtemp_shutdown: assert property (switch_overtemp[0] [*3] |=> fault_status_second[0] &&
		!channel_action.switching_enable[0] && channel_action.comp_discharge[0]) else $error("overtemp not handled");
	chk_bootstrap_low: assert property (bootstrap_uv[1] [*3] |=> channel_action.force_low_side[1] &&
		fault_status_second[3]) else $error("bootstrap uv not handled");
	chk_input_uv_stop: assert property (input_uv[1] [*3] |=> !channel_action.switching_enable[1])
		else $error("input uv left channel switching");
	chk_analog_uv_flag: assert property (analog_bias_uv [*3] |=> fault_status_third[2] &&
		channel_action.comp_discharge == 2'h3 && channel_action.switching_enable == 2'h0) else $error("analog uv");
	chk_power_cycle_clear: assert property (read_done_third |=> !fault_status_third[3])
		else $error("power cycle flag not cleared");
	chk_bias_code: assert property (adc_valid && adc_source == fault_monitor_pkg::ADC_SRC_DIGITAL_BIAS |=>
		digital_bias_supply == 8'($past(adc_data) >> 2)) else $error("bias code wrong");
	chk_serial_flag: assert property (serial_error |-> ##[2:3] fault_status_third[1])
		else $error("serial error flag missing");
	cover property (fault_status_third[5:4] == 2'h3);
	cover property (bootstrap_uv[1] [*3]);
	cover property (read_done_third && fault_status_third[3]);
endmodule

bind led_driver_fault_monitor fault_monitor_checker fault_monitor_checker_inst (.clk(clk), .rst_n(rst_n),
	.switch_overtemp(switch_overtemp), .bootstrap_uv(bootstrap_uv), .input_uv(input_uv), .comp_ov(comp_ov),
	.analog_bias_uv(analog_bias_uv), .adc_valid(adc_valid), .adc_source(adc_source), .adc_data(adc_data),
	.serial_error(serial_error), .read_done_third(read_done_third), .digital_bias_supply(digital_bias_supply),
	.fault_status_first(fault_status_first), .fault_status_second(fault_status_second),
	.fault_status_third(fault_status_third), .channel_action(channel_action));

/* File: tb/host_model.sv */
// host model: serial reads and transfers toward the monitor
`timescale 1ns/10ps
module host_model (
	// clock
	input wire logic clk,
	// serial events
	output logic spi_activity,
	output logic read_done_first,
	output logic read_done_second,
	output logic read_done_third,
	output logic read_die_temp_low
);
	logic [4:0] ev = 5'h00;
	assign {spi_activity, read_done_first, read_done_second, read_done_third, read_die_temp_low} = ev;
	// one-cycle event, launched and dropped on rising edges
	task automatic pulse(input logic [4:0] e);
		@(posedge clk) ev <= e;
		@(posedge clk) ev <= 5'h00;
	endtask
	// low byte first so the high byte belongs to the same sample
	task automatic read_temp();
		pulse(5'h01);
	endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench for the led driver fault monitor
`timescale 1ns/10ps
module tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] switch_overtemp = 2'h0, bootstrap_uv = 2'h0, input_uv = 2'h0, comp_ov = 2'h0, channel_enable = 2'h0;
	logic analog_bias_uv = 1'b0, adc_valid = 1'b0, serial_error = 1'b0, watchdog_enable = 1'b0;
	logic limp_home_select = 1'b0;
	fault_monitor_pkg::adc_source_t adc_source = fault_monitor_pkg::ADC_SRC_OTHER;
	logic [9:0] adc_data = 10'h000, thermal_warning_limit = 10'h3FF, current_reference;
	logic [4:0] watchdog_tap_select = 5'h03;
	logic spi_activity, read_done_first, read_done_second, read_done_third, read_die_temp_low;
	logic [7:0] digital_bias_supply, limp_ref_low_byte, limp_ref_high_byte, die_temp_low_byte, die_temp_high_byte;
	logic [7:0] fault_status_first, fault_status_second, fault_status_third;
	fault_monitor_pkg::channel_action_t channel_action;
	fault_monitor_pkg::op_mode_t op_mode;
	logic [9:0] bias = 10'h000, limp = 10'h000, temp = 10'h000, held = 10'h000, d;
	logic [1:0] m;
	int s;
	int n_fail = 0;
	int samples_checked = 0;

	led_driver_fault_monitor led_driver_fault_monitor_inst (.*);
	host_model host_model_inst (.*);

	always #25 clk = ~clk;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic warn(input logic [9:0] t, input logic [9:0] lim);
		return t[9:2] > lim[9:2];
	endfunction
	task automatic rd(input logic [4:0] e);
		host_model_inst.pulse(e);
		tick(2);
	endtask
	task automatic drive(input int k, input logic [1:0] v);
		@(posedge clk);
		case (k)
			0: comp_ov <= v;
			1: switch_overtemp <= v;
			2: bootstrap_uv <= v;
			default: input_uv <= v;
		endcase
	endtask
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	initial begin
		#150000;
		n_fail++;
		report_and_stop();
	end

	initial begin
		void'($urandom(77170));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		tick(1);
		chk(fault_status_third, 8'h08);
		rd(5'h02);
		chk(fault_status_third, 8'h00);
		@(posedge clk) channel_enable <= 2'h3;
		for (int k = 0; k < 4; k++) begin
			for (int ch = 0; ch < 2; ch++) begin
				m = 2'(1 << ch);
				drive(k, m);
				tick(4);
				case (k)
					0: begin
						chk(fault_status_first, {6'h00, m});
						chk(8'(channel_action), 8'h30);
						rd(5'h08);
						chk(fault_status_first, {6'h00, m});
					end
					1: begin
						chk(fault_status_second, {6'h00, m});
						chk(8'(channel_action), {2'h0, ~m, 2'h0, m});
					end
					2: begin
						chk(fault_status_second, {4'h0, m, 2'h0});
						chk(8'(channel_action.force_low_side), {6'h00, m});
					end
					default: begin
						chk(fault_status_second | fault_status_first, 8'h00);
						chk(8'(channel_action.switching_enable), {6'h00, ~m});
					end
				endcase
				drive(k, 2'h0);
				tick(4);
				rd(k == 0 ? 5'h08 : 5'h04);
				chk(fault_status_first | fault_status_second, 8'h00);
				chk(8'(channel_action), 8'h30);
			end
		end
		@(posedge clk) analog_bias_uv <= 1'b1;
		serial_error <= 1'b1;
		@(posedge clk) serial_error <= 1'b0;
		tick(4);
		chk(fault_status_third, 8'h06);
		chk(8'(channel_action), 8'h03);
		@(posedge clk) analog_bias_uv <= 1'b0;
		thermal_warning_limit <= 10'($urandom);
		tick(4);
		rd(5'h02);
		chk(fault_status_third, 8'h00);
		for (int i = 0; i < 30; i++) begin
			s = i < 3 ? i : int'($urandom_range(3));
			d = i < 6 ? (i < 3 ? 10'h3FF : 10'h000) : 10'($urandom);
			@(posedge clk) adc_valid <= 1'b1;
			adc_source <= fault_monitor_pkg::adc_source_t'(s);
			adc_data <= d;
			@(posedge clk) adc_valid <= 1'b0;
			tick(3);
			case (s)
				0: bias = d;
				1: limp = d;
				2: temp = d;
				default: begin
				end
			endcase
			chk(digital_bias_supply, bias[9:2]);
			chk(limp_ref_low_byte, limp[7:0]);
			chk(limp_ref_high_byte, {6'h00, limp[9:8]});
			chk(die_temp_low_byte, held[7:0]);
			if (s == 2) begin
				rd(5'h02);
				chk(fault_status_third, {7'h00, warn(temp, thermal_warning_limit)});
			end
			if ($urandom_range(1) == 1) begin
				host_model_inst.read_temp();
				tick(2);
				held = temp;
				chk(die_temp_low_byte, held[7:0]);
				chk(die_temp_high_byte, {6'h00, held[9:8]});
			end
		end
		@(posedge clk) thermal_warning_limit <= 10'h3FF;
		rd(5'h02);
		chk(fault_status_third, 8'h00);
		@(posedge clk) limp_home_select <= 1'b1;
		watchdog_enable <= 1'b1;
		tick(13);
		chk(fault_status_third, 8'h10);
		chk(8'(op_mode), 8'(fault_monitor_pkg::OP_LIMP_HOME));
		chk(current_reference[7:0], limp[7:0]);
		chk({6'h00, current_reference[9:8]}, {6'h00, limp[9:8]});
		tick(30);
		chk(fault_status_third, 8'h30);
		@(posedge clk) limp_home_select <= 1'b0;
		rd(5'h10);
		chk(8'(op_mode), 8'(fault_monitor_pkg::OP_NORMAL));
		chk(8'(current_reference != 10'h000), 8'h00);
		tick(10);
		chk(8'(op_mode), 8'(fault_monitor_pkg::OP_STAND_ALONE));
		@(posedge clk) watchdog_enable <= 1'b0;
		@(posedge clk) rst_n <= 1'b0;
		tick(2);
		chk(fault_status_third, 8'h08);
		chk(8'(channel_action), 8'h03);
		@(posedge clk) rst_n <= 1'b1;
		tick(2);
		chk(digital_bias_supply, 8'h00);
		chk(8'(op_mode), 8'(fault_monitor_pkg::OP_NORMAL));
		report_and_stop();
	end
endmodule
